// >>> bench/cvd_conv_model.sv
// Purpose: behavioural converter behind the control block
// Assumes: start is a level that the block clears after done
// Notes: raw toggles outside the done cycle
module cvd_conv_model #(parameter LAT = 4) (
  input logic clk, // clock
  input logic reset, // reset
  input logic start, // start flag
  input logic slow, // stretch conversion
  input logic [9:0] value, // result to deliver
  output logic done, // one-cycle completion
  output logic [9:0] raw // result, valid with done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt; // cycles converting
  initial begin
    done = 1'h0;
    raw = 10'h000;
  end
  // count the conversion, pulse done once
  always @(posedge clk) begin
    done <= 1'h0;
    raw <= ~raw;
    if (reset || !start || done) begin
      cnt <= 0;
    end else if (cnt >= (slow ? 4 * LAT : LAT)) begin
      done <= 1'h1;
      raw <= value;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> bench/cvd_trigger_ctrl_sva.sv
// Purpose: port checker of the converter control block
// Assumes: one clock, synchronous active high reset
// Notes: small shadows follow written fields
module cvd_ctrl_chk #(parameter NSEC = 7) (
  input logic clk, // clock
  input logic reset, // reset
  input logic [2:0] addr, // address
  input logic [7:0] wdata, // write data
  input logic wr_stb, // write strobe
  input logic rd_stb, // read strobe
  input logic [7:0] rdata, // read data
  input logic tmr0_ovf, // timer 0 event
  input logic adc1_done, // done 1
  input logic [9:0] adc1_raw, // raw 1
  input logic [NSEC-1:0] pin_direction_control1, // direction 1
  input logic [NSEC-1:0] adc1_sec_link, // links 1
  input logic [NSEC-1:0] pin_tristate1, // tristate 1
  input logic adc1_mux_on, // enable 1
  input logic [4:0] adc1_primary, // primary 1
  input logic adc1_start, // start 1
  input logic adc2_start, // start 2
  input logic [6:0] conv_clk_div, // divider
  input logic dedicated_rc_clock, // rc clock
  input logic [7:0] adc1_result_high_byte, // high byte
  input logic [7:0] adc1_result_low_byte // low byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // shadows
  logic just_reg; // justify bit
  logic [2:0] trig_reg; // trigger code
  logic [9:0] raw_reg; // raw one cycle back
  wire [4:0] rel = adc1_primary - 5'h0a; // primary offset in group
  // follow writes so that the checks know the mode
  always @(posedge clk) begin
    raw_reg <= adc1_raw;
    if (reset) begin
      just_reg <= 1'h0;
      trig_reg <= 3'h0;
    end else if (wr_stb && addr == 3'h2) begin
      just_reg <= wdata[7];
    end else if (wr_stb && addr == 3'h3) begin
      trig_reg <= wdata[6:4];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // properties
  sequence s_sync_go;
    wr_stb && addr == 3'h2 && wdata[2] && adc1_mux_on;
  endsequence
  sequence s_run;
    adc1_start ##1 1'h1;
  endsequence
  property p_off_open;
    !adc1_mux_on |-> adc1_sec_link == 7'h00 && pin_tristate1 == pin_direction_control1;
  endproperty
  property p_tri;
    (adc1_sec_link & ~pin_tristate1) == 7'h00;
  endproperty
  property p_prim;
    adc1_primary >= 5'h0a && adc1_primary <= 5'h10 |-> !adc1_sec_link[rel[2:0]];
  endproperty
  property p_unimpl;
    rd_stb && addr == 3'h3 |=> rdata[7] == 1'h0 && rdata[3:0] == 4'h0;
  endproperty
  property p_sync;
    s_sync_go |=> s_run;
  endproperty
  property p_or_rd;
    rd_stb && addr == 3'h2 |=> rdata[2] == $past(adc1_start | adc2_start);
  endproperty
  property p_done_clr;
    adc1_start && adc1_done && !wr_stb |=> !adc1_start;
  endproperty
  property p_tmr0;
    trig_reg == 3'h3 && tmr0_ovf && adc1_mux_on |-> ##[1:3] adc1_start;
  endproperty
  property p_just_r;
    adc1_done && just_reg |=> adc1_result_high_byte == {6'h00, raw_reg[9:8]}
      && adc1_result_low_byte == raw_reg[7:0];
  endproperty
  property p_just_l;
    adc1_done && !just_reg |=> adc1_result_high_byte == raw_reg[9:2]
      && adc1_result_low_byte == {raw_reg[1:0], 6'h00};
  endproperty
  property p_clk;
    dedicated_rc_clock == (conv_clk_div == 7'h00);
  endproperty
  a_off_open: assert property (p_off_open)
    else $error("link or tristate active while disabled");
  a_tri: assert property (p_tri)
    else $error("closed link on driven pin");
  a_prim: assert property (p_prim)
    else $error("secondary link on primary channel");
  a_unimpl: assert property (p_unimpl)
    else $error("unused trigger bits read nonzero");
  a_sync: assert property (p_sync)
    else $error("sync start did not start converter");
  a_or_rd: assert property (p_or_rd)
    else $error("sync bit not or of starts");
  a_done_clr: assert property (p_done_clr)
    else $error("start not cleared on done");
  a_tmr0: assert property (p_tmr0)
    else $error("timer trigger did not start");
  a_just_r: assert property (p_just_r)
    else $error("right justified result wrong");
  a_just_l: assert property (p_just_l)
    else $error("left justified result wrong");
  a_clk: assert property (p_clk)
    else $error("rc flag and divider disagree");
endmodule
bind cvd_trigger_ctrl cvd_ctrl_chk #(.NSEC(NSEC)) chk_i (.clk, .reset, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .tmr0_ovf, .adc1_done, .adc1_raw, .pin_direction_control1, .adc1_sec_link,
  .pin_tristate1, .adc1_mux_on, .adc1_primary, .adc1_start, .adc2_start, .conv_clk_div,
  .dedicated_rc_clock, .adc1_result_high_byte, .adc1_result_low_byte);

// >>> bench/dual_adc_cvd_channel_trigger_ctrl_tb_top.sv
// Purpose: self-checking bench of the converter control block
// Assumes: offsets 0..5 mapped, 6 and 7 unmapped
// Notes: reads are noted in a queue and checked by a monitor
module dual_adc_cvd_channel_trigger_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, reset = 1'h1, wr_stb = 1'h0, rd_stb = 1'h0, rd_d = 1'h0; // bus
  logic tmr0_ovf = 1'h0, tmr1_ovf = 1'h0, tmr2_match = 1'h0, slow = 1'h0; // events
  logic external_trigger_pin = 1'h0, adc1_done, adc2_done; // pins
  logic [2:0] addr = 3'h0; // address
  logic [7:0] wdata = 8'h00, rdata, e8; // data
  logic [9:0] adc1_raw, adc2_raw, val1 = 10'h000, val2 = 10'h000; // results
  logic [6:0] pin_direction_control1 = 7'h00, pin_direction_control2 = 7'h00; // directions
  logic [6:0] adc1_sec_link, adc2_sec_link, pin_tristate1, pin_tristate2; // channels
  logic [6:0] conv_clk_div, s1, s2; // divider and scratch
  logic adc1_mux_on, adc2_mux_on, adc1_start, adc2_start, dedicated_rc_clock; // states
  logic [4:0] adc1_primary, adc2_primary, p1, p2; // primaries
  logic [1:0] upper_reference_node; // reference
  logic [7:0] adc1_result_high_byte, adc1_result_low_byte; // results 1
  logic [7:0] adc2_result_high_byte, adc2_result_low_byte; // results 2
  logic [31:0] rs = 32'h675b54c1; // random state
  logic [7:0] q[$]; // expected reads
  int fails = 0, comparisons = 0, i, n, k; // counters
  logic [7:0] mk [8] = '{8'h7f, 8'h7f, 8'hf7, 8'h70, 8'h7f, 8'h7f, 8'h00, 8'h00}; // masks
  logic [6:0] dv [8] = '{7'h02, 7'h08, 7'h20, 7'h00, 7'h04, 7'h10, 7'h40, 7'h00}; // ratios
  logic [2:0] tc [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7}; // trigger codes
  cvd_trigger_ctrl dut (.clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .tmr0_ovf,
    .tmr1_ovf, .tmr2_match, .external_trigger_pin, .adc1_done, .adc2_done, .adc1_raw,
    .adc2_raw, .pin_direction_control1, .pin_direction_control2, .adc1_sec_link,
    .adc2_sec_link, .pin_tristate1, .pin_tristate2, .adc1_mux_on, .adc2_mux_on,
    .adc1_primary, .adc2_primary, .adc1_start, .adc2_start, .conv_clk_div,
    .dedicated_rc_clock, .upper_reference_node, .adc1_result_high_byte,
    .adc1_result_low_byte, .adc2_result_high_byte, .adc2_result_low_byte);
  cvd_conv_model #(.LAT(4)) m1 (.clk, .reset, .start(adc1_start), .slow, .value(val1),
    .done(adc1_done), .raw(adc1_raw));
  cvd_conv_model #(.LAT(6)) m2 (.clk, .reset, .start(adc2_start), .slow, .value(val2),
    .done(adc2_done), .raw(adc2_raw));
  always #20 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    q.push_back(e);
    @(posedge clk);
    rd_stb <= 1'h0;
  endtask
  task automatic results;
    $display("checks %0d failed %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // monitor: compare read data with the oldest note
  always @(posedge clk) begin
    rd_d <= rd_stb;
    if (rd_d) chk("rdata", rdata, q.pop_front());
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results;
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    for (i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    for (i = 0; i < 8; i++) begin
      rs = lfsr(rs);
      wr(i[2:0], rs[7:0] & 8'hf9);
      rd(i[2:0], rs[7:0] & 8'hf9 & mk[i]);
    end
    $display("test registers done");
    for (i = 0; i < 12; i++) begin
      rs = lfsr(rs);
      pin_direction_control1 <= rs[6:0];
      pin_direction_control2 <= rs[13:7];
      p1 = 5'h0a + rs[18:16];
      p2 = 5'h14 + rs[21:19];
      wr(3'h0, {1'h0, rs[28:22]});
      wr(3'h1, {1'h0, rs[31:25]});
      wr(3'h4, {1'h0, p1, 1'h0, rs[14]});
      wr(3'h5, {1'h0, p2, 1'h0, rs[15]});
      @(negedge clk);
      s1 = {7{rs[14]}} & rs[28:22];
      s2 = {7{rs[15]}} & rs[31:25];
      chk("link1", 8'(adc1_sec_link), 8'(s1 & ~(7'h01 << rs[18:16])));
      chk("link2", 8'(adc2_sec_link), 8'(s2 & ~(7'h01 << rs[21:19])));
      chk("tri1", 8'(pin_tristate1), 8'(s1 | rs[6:0]));
      chk("tri2", 8'(pin_tristate2), 8'(s2 | rs[13:7]));
      chk("prim1", {adc1_mux_on, 2'h0, adc1_primary}, {rs[14], 2'h0, p1});
    end
    $display("test channels done");
    for (i = 0; i < 8; i++) begin
      wr(3'h2, {1'h0, i[2:0], 2'h0, i[1:0]});
      @(negedge clk);
      chk("div", 8'(conv_clk_div), 8'(dv[i]));
      chk("rc", 8'(dedicated_rc_clock), 8'(i[1:0] == 2'h3));
      chk("ref", 8'(upper_reference_node), 8'(i[1:0]));
    end
    $display("test clock and reference done");
    for (i = 0; i < 2; i++) begin
      rs = lfsr(rs);
      val1 <= rs[9:0];
      val2 <= rs[19:10];
      slow <= i[0];
      wr(3'h4, 8'h01);
      wr(3'h5, {7'h00, i[0]});
      wr(3'h2, {i[0], 7'h04});
      @(negedge clk);
      chk("go", 8'({adc1_start, adc2_start}), 8'({1'h1, i[0]}));
      rd(3'h2, {i[0], 7'h04});
      n = 0;
      while ((adc1_start | adc2_start) && n < 200) begin
        @(negedge clk);
        n++;
      end
      e8 = i[0] ? {6'h00, val1[9:8]} : val1[9:2];
      chk("high1", adc1_result_high_byte, e8);
      chk("low1", adc1_result_low_byte, i[0] ? val1[7:0] : {val1[1:0], 6'h00});
      rd(3'h2, {i[0], 7'h00});
    end
    $display("test sync start done");
    for (i = 0; i < 6; i++) begin
      wr(3'h3, {1'h0, tc[i], 4'h0});
      @(posedge clk);
      tmr0_ovf <= tc[i] == 3'h3 || tc[i] == 3'h0;
      tmr1_ovf <= tc[i] == 3'h4 || tc[i] == 3'h0;
      tmr2_match <= tc[i] == 3'h5 || tc[i] == 3'h0;
      external_trigger_pin <= tc[i] == 3'h6;
      @(posedge clk);
      tmr0_ovf <= 1'h0;
      tmr1_ovf <= 1'h0;
      tmr2_match <= 1'h0;
      n = 0;
      k = 0;
      repeat (40) begin
        @(negedge clk);
        if (adc1_start && k == 0) n++;
        k = adc1_start;
      end
      chk("trig", 8'(n), 8'(tc[i] != 3'h0));
    end
    $display("test triggers done");
    results;
  end
endmodule

// >>> rtl/cvd_trigger_ctrl.v
// Purpose: register file, channel switching, trigger and start logic of a dual converter
// Assumes: converters report done pulses and raw results on clk
// Notes: analog switch and reference outputs are levels for the analog front end
//
// The plain strobed port and the placing of the registers were decided locally.
`include "cvd_trigger_regs.vh"

module cvd_trigger_ctrl #(
  parameter NSEC = 7 // secondary channels per converter
) (
  input wire clk, // system clock
  input wire reset, // synchronous reset, active high
  input wire [2:0] addr, // register address
  input wire [7:0] wdata, // write data
  input wire wr_stb, // write strobe
  input wire rd_stb, // read strobe
  output reg [7:0] rdata, // read data, cycle after the strobe
  input wire tmr0_ovf, // timer 0 overflow flag event
  input wire tmr1_ovf, // timer 1 overflow flag event
  input wire tmr2_match, // timer 2 period match flag event
  input wire external_trigger_pin, // external trigger pin, asynchronous
  input wire adc1_done, // converter 1 finished, one cycle
  input wire adc2_done, // converter 2 finished, one cycle
  input wire [9:0] adc1_raw, // converter 1 raw result
  input wire [9:0] adc2_raw, // converter 2 raw result
  input wire [NSEC-1:0] pin_direction_control1, // direction bits, inputs 10..16
  input wire [NSEC-1:0] pin_direction_control2, // direction bits, inputs 20..26
  output wire [NSEC-1:0] adc1_sec_link, // secondary switches of converter 1
  output wire [NSEC-1:0] adc2_sec_link, // secondary switches of converter 2
  output wire [NSEC-1:0] pin_tristate1, // effective tri-state, inputs 10..16
  output wire [NSEC-1:0] pin_tristate2, // effective tri-state, inputs 20..26
  output wire adc1_mux_on, // converter 1 primary switch closed
  output wire adc2_mux_on, // converter 2 primary switch closed
  output wire [4:0] adc1_primary, // converter 1 primary channel
  output wire [4:0] adc2_primary, // converter 2 primary channel
  output wire adc1_start, // converter 1 start bit
  output wire adc2_start, // converter 2 start bit
  output wire [6:0] conv_clk_div, // divider ratio, zero when rc clock
  output wire dedicated_rc_clock, // rc oscillator selected
  output wire [1:0] upper_reference_node, // reference route code
  output reg [7:0] adc1_result_high_byte, // converter 1 high result byte
  output reg [7:0] adc1_result_low_byte, // converter 1 low result byte
  output reg [7:0] adc2_result_high_byte, // converter 2 high result byte
  output reg [7:0] adc2_result_low_byte // converter 2 low result byte
);

  // ==========================================================
  // register storage
  reg [7:0] sec1_reg; // converter 1 secondary select
  reg [7:0] sec2_reg; // converter 2 secondary select
  reg [7:0] shared_reg; // shared control, start bit held apart
  reg [7:0] trig_reg; // auto trigger select
  reg [4:0] chs1_reg; // converter 1 primary channel
  reg [4:0] chs2_reg; // converter 2 primary channel
  reg on1_reg; // converter 1 enable
  reg on2_reg; // converter 2 enable
  reg go1_reg; // converter 1 start flag
  reg go2_reg; // converter 2 start flag
  reg go1_next; // next start flag 1
  reg go2_next; // next start flag 2

  // ==========================================================
  // external trigger synchroniser
  reg sync_a_reg; // first stage, read only by second
  reg sync_b_reg; // second stage
  reg sync_c_reg; // third stage
  reg pin_level_reg; // accepted pin level
  reg trig_pulse; // selected trigger event this cycle

  // agreeing stages update the accepted level
  always @(posedge clk) begin
    if (reset) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
      sync_c_reg <= 1'b0;
      pin_level_reg <= 1'b0;
    end else begin
      sync_a_reg <= external_trigger_pin;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
      if (sync_b_reg == sync_c_reg) begin
        pin_level_reg <= sync_c_reg;
      end
    end
  end

  // pick one trigger pulse per event
  always @* begin
    case (trig_reg[`F_TRIG_HI:`F_TRIG_LO])
      `TRG_TMR0: trig_pulse = tmr0_ovf;
      `TRG_TMR1: trig_pulse = tmr1_ovf;
      `TRG_TMR2: trig_pulse = tmr2_match;
      `TRG_RISE: trig_pulse = (sync_b_reg == sync_c_reg) && sync_c_reg && !pin_level_reg;
      `TRG_FALL: trig_pulse = (sync_b_reg == sync_c_reg) && !sync_c_reg && pin_level_reg;
      default: trig_pulse = 1'b0; // none and reserved codes
    endcase
  end

  // ==========================================================
  // register writes
  wire wr_sec1 = wr_stb && (addr == `OFF_ADC1_SEC);
  wire wr_sec2 = wr_stb && (addr == `OFF_ADC2_SEC);
  wire wr_shared = wr_stb && (addr == `OFF_SHARED);
  wire wr_trig = wr_stb && (addr == `OFF_TRIG);
  wire wr_main1 = wr_stb && (addr == `OFF_ADC1_MAIN);
  wire wr_main2 = wr_stb && (addr == `OFF_ADC2_MAIN);
  wire sync_go = wr_shared && wdata[`F_SYNC_GO];

  // start flags: set beats completion, completion beats software clear
  always @* begin
    go1_next = go1_reg;
    go2_next = go2_reg;
    if (wr_main1) begin
      go1_next = wdata[`F_GO];
    end
    if (wr_main2) begin
      go2_next = wdata[`F_GO];
    end
    if (adc1_done) begin
      go1_next = 1'b0;
    end
    if (adc2_done) begin
      go2_next = 1'b0;
    end
    if (sync_go || trig_pulse || (wr_main1 && wdata[`F_GO])) begin
      go1_next = 1'b1;
    end
    if (sync_go || trig_pulse || (wr_main2 && wdata[`F_GO])) begin
      go2_next = 1'b1;
    end
    if (!(wr_main1 ? wdata[`F_ON] : on1_reg)) begin
      go1_next = 1'b0;
    end
    if (!(wr_main2 ? wdata[`F_ON] : on2_reg)) begin
      go2_next = 1'b0;
    end
  end

  // store registers
  always @(posedge clk) begin
    if (reset) begin
      sec1_reg <= `RST_BYTE;
      sec2_reg <= `RST_BYTE;
      shared_reg <= `RST_BYTE;
      trig_reg <= `RST_BYTE;
      chs1_reg <= 5'h00;
      chs2_reg <= 5'h00;
      on1_reg <= 1'b0;
      on2_reg <= 1'b0;
      go1_reg <= 1'b0;
      go2_reg <= 1'b0;
    end else begin
      go1_reg <= go1_next;
      go2_reg <= go2_next;
      if (wr_sec1) begin
        sec1_reg <= wdata & `SEC_MASK;
      end
      if (wr_sec2) begin
        sec2_reg <= wdata & `SEC_MASK;
      end
      if (wr_shared) begin
        shared_reg <= wdata & `SHARED_MASK & ~(8'h01 << `F_SYNC_GO);
      end
      if (wr_trig) begin
        trig_reg <= wdata & `TRIG_MASK;
      end
      if (wr_main1) begin
        chs1_reg <= wdata[`F_CHS_HI:`F_CHS_LO];
        on1_reg <= wdata[`F_ON];
      end
      if (wr_main2) begin
        chs2_reg <= wdata[`F_CHS_HI:`F_CHS_LO];
        on2_reg <= wdata[`F_ON];
      end
    end
  end

  // ==========================================================
  // register reads, answer in the next cycle
  always @(posedge clk) begin
    if (reset) begin
      rdata <= `RST_BYTE;
    end else if (rd_stb) begin
      if (addr == `OFF_ADC1_SEC) begin
        rdata <= sec1_reg;
      end else if (addr == `OFF_ADC2_SEC) begin
        rdata <= sec2_reg;
      end else if (addr == `OFF_SHARED) begin
        rdata <= shared_reg | ({7'h00, go1_reg | go2_reg} << `F_SYNC_GO);
      end else if (addr == `OFF_TRIG) begin
        rdata <= trig_reg;
      end else if (addr == `OFF_ADC1_MAIN) begin
        rdata <= {1'b0, chs1_reg, go1_reg, on1_reg};
      end else if (addr == `OFF_ADC2_MAIN) begin
        rdata <= {1'b0, chs2_reg, go2_reg, on2_reg};
      end else begin
        rdata <= `RST_BYTE; // unmapped reads zero
      end
    end else begin
      rdata <= `RST_BYTE;
    end
  end

  // ==========================================================
  // channel switching per secondary input
  genvar i;
  generate
    for (i = 0; i < NSEC; i = i + 1) begin : g_sec
      wire prim1 = (chs1_reg == (`CHS_ADC1_BASE + i));
      wire prim2 = (chs2_reg == (`CHS_ADC2_BASE + i));
      assign adc1_sec_link[i] = on1_reg && sec1_reg[i] && !prim1;
      assign adc2_sec_link[i] = on2_reg && sec2_reg[i] && !prim2;
      assign pin_tristate1[i] = pin_direction_control1[i] | (on1_reg & sec1_reg[i]);
      assign pin_tristate2[i] = pin_direction_control2[i] | (on2_reg & sec2_reg[i]);
    end
  endgenerate

  // primary and secondaries close together, both see precharge
  assign adc1_mux_on = on1_reg;
  assign adc2_mux_on = on2_reg;
  assign adc1_primary = chs1_reg;
  assign adc2_primary = chs2_reg;
  assign adc1_start = go1_reg;
  assign adc2_start = go2_reg;
  assign upper_reference_node = shared_reg[`F_REF_HI:`F_REF_LO];

  // ==========================================================
  // conversion clock selection
  reg [6:0] div_sel; // divider ratio
  always @* begin
    case (shared_reg[`F_CLK_HI:`F_CLK_LO])
      `CLK_DIV2: div_sel = `DIV_TWO;
      `CLK_DIV8: div_sel = `DIV_EIGHT;
      `CLK_DIV32: div_sel = `DIV_THIRTYTWO;
      `CLK_DIV4: div_sel = `DIV_FOUR;
      `CLK_DIV16: div_sel = `DIV_SIXTEEN;
      `CLK_DIV64: div_sel = `DIV_SIXTYFOUR;
      default: div_sel = 7'h00; // rc oscillator
    endcase
  end
  assign conv_clk_div = div_sel;
  assign dedicated_rc_clock = (div_sel == 7'h00);

  // ==========================================================
  // result bytes loaded on completion
  wire just = shared_reg[`F_JUSTIFY];
  always @(posedge clk) begin
    if (reset) begin
      adc1_result_high_byte <= `RST_BYTE;
      adc1_result_low_byte <= `RST_BYTE;
      adc2_result_high_byte <= `RST_BYTE;
      adc2_result_low_byte <= `RST_BYTE;
    end else begin
      if (adc1_done) begin
        if (just) begin
          adc1_result_high_byte <= {`RES_ZERO6, adc1_raw[9:8]};
          adc1_result_low_byte <= adc1_raw[7:0];
        end else begin
          adc1_result_high_byte <= adc1_raw[9:2];
          adc1_result_low_byte <= {adc1_raw[1:0], `RES_ZERO6};
        end
      end
      if (adc2_done) begin
        if (just) begin
          adc2_result_high_byte <= {`RES_ZERO6, adc2_raw[9:8]};
          adc2_result_low_byte <= adc2_raw[7:0];
        end else begin
          adc2_result_high_byte <= adc2_raw[9:2];
          adc2_result_low_byte <= {adc2_raw[1:0], `RES_ZERO6};
        end
      end
    end
  end

endmodule

// >>> rtl/cvd_trigger_regs.vh
// Purpose: register offsets, field positions and codes of the converter control block
// Assumes: included once by the control module
// Notes: offsets are chosen for this plain register port
`ifndef CVD_TRIGGER_REGS_VH
`define CVD_TRIGGER_REGS_VH

// ==========================================================
// register offsets
`define OFF_ADC1_SEC 3'h0
`define OFF_ADC2_SEC 3'h1
`define OFF_SHARED 3'h2
`define OFF_TRIG 3'h3
`define OFF_ADC1_MAIN 3'h4
`define OFF_ADC2_MAIN 3'h5

// ==========================================================
// reset values and masks
`define RST_BYTE 8'h00
`define SEC_MASK 8'h7f
`define SHARED_MASK 8'hf7
`define TRIG_MASK 8'h70
`define MAIN_MASK 8'h7f

// ==========================================================
// field positions
`define F_JUSTIFY 7
`define F_CLK_HI 6
`define F_CLK_LO 4
`define F_SYNC_GO 2
`define F_REF_HI 1
`define F_REF_LO 0
`define F_TRIG_HI 6
`define F_TRIG_LO 4
`define F_CHS_HI 6
`define F_CHS_LO 2
`define F_GO 1
`define F_ON 0

// ==========================================================
// conversion clock codes
`define CLK_DIV2 3'h0
`define CLK_DIV8 3'h1
`define CLK_DIV32 3'h2
`define CLK_RC_A 3'h3
`define CLK_DIV4 3'h4
`define CLK_DIV16 3'h5
`define CLK_DIV64 3'h6
`define CLK_RC_B 3'h7

// ==========================================================
// positive reference codes
`define REF_SUPPLY 2'h0
`define REF_RESVD 2'h1
`define REF_PIN 2'h2
`define REF_FIXED 2'h3

// ==========================================================
// trigger source codes
`define TRG_NONE 3'h0
`define TRG_TMR0 3'h3
`define TRG_TMR1 3'h4
`define TRG_TMR2 3'h5
`define TRG_RISE 3'h6
`define TRG_FALL 3'h7

// ==========================================================
// primary channel codes that meet the secondary groups
`define CHS_ADC1_BASE 5'h0a
`define CHS_ADC2_BASE 5'h14

// ==========================================================
// result format and divider ratios
`define RES_WIDTH 10
`define RES_ZERO6 6'h00
`define DIV_ONE 7'h01
`define DIV_TWO 7'h02
`define DIV_FOUR 7'h04
`define DIV_EIGHT 7'h08
`define DIV_SIXTEEN 7'h10
`define DIV_THIRTYTWO 7'h20
`define DIV_SIXTYFOUR 7'h40

`endif
